// file: rtl/dbe_debug_ctrl.sv
// Debug entry arbitration, debug-state isolation and test port top
`timescale 1ns/10ps
`default_nettype none
module dbe_debug_ctrl
  import dbe_pkg::*;
#(
  parameter bit EXT_BSCAN_EN = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ex_valid,
  input  wire logic        ex_bkpt,
  input  wire logic        external_breakpoint_in,
  input  wire logic        ex_prefetch_abort,
  input  wire logic        software_interrupt_instruction,
  input  wire logic        ex_undefined,
  input  wire logic        ex_single_cycle,
  input  wire logic        ex_done,
  input  wire logic        normal_interrupt,
  input  wire logic        fast_interrupt,
  input  wire logic        watchpoint,
  input  wire logic        data_abort,
  input  wire logic        exc_entry_done,
  input  wire logic        ice_debug_request,
  input  wire logic        external_debug_request,
  input  wire logic        debug_restart,
  input  wire logic [31:0] next_pc,
  input  wire logic        pipe_imreq_n,
  input  wire logic        pipe_instr_sequential,
  input  wire logic        pipe_dmreq_n,
  input  wire logic        pipe_data_sequential,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  input  wire logic        trst_n,
  output logic             take_prefetch_abort,
  output logic             take_data_abort,
  output logic             take_swi,
  output logic             take_undefined,
  output logic             take_irq,
  output logic             take_fiq,
  output logic             ex_discard,
  output logic             ex_cancel,
  output logic             issue_hold,
  output logic             int_blocked,
  output logic             debug_acknowledge,
  output logic [31:0]      debug_pc,
  output logic             instr_mem_request_n,
  output logic             instr_sequential,
  output logic             data_mem_request_n,
  output logic             data_sequential,
  output logic [3:0]       tap_state_out,
  output logic [IR_W-1:0]  tap_ir_out,
  output logic [SCAN_W-1:0] scan_chain_select_out,
  output logic             scan_chain_internal,
  output logic             scan_chain_present,
  output logic             system_mode,
  output logic             tdo,
  output logic             tdo_oe_n
);
  logic [1:0]   drq_s;
  logic [2:0]   tap_s;
  logic         drq_any;
  logic         bkpt_any;
  logic         int_req;
  logic         in_dbg_next;
  dbe_core_st_t st_ff;
  dbe_core_st_t nxt_st;
  logic         nxt_pabort;
  logic         nxt_dabort;
  logic         nxt_swi;
  logic         nxt_undef;
  logic         nxt_irq;
  logic         nxt_fiq;
  logic         nxt_discard;
  logic         nxt_cancel;
  logic         wp_entry;

  // Both request sources cross in; the comparator unit may run off core clock
  dbe_sync2 #(
    .W (2)
  ) u_drq_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({ice_debug_request, external_debug_request}),
    .q        (drq_s)
  );

  dbe_sync2 #(
    .W (3)
  ) u_tap_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({tck, tms, tdi}),
    .q        (tap_s)
  );

  dbe_tap_ctrl u_tap (
    .core_clk              (core_clk),
    .rst                   (rst),
    .trst_n                (trst_n),
    .tck_s                 (tap_s[2]),
    .tms_s                 (tap_s[1]),
    .tdi_s                 (tap_s[0]),
    .tap_state_out         (tap_state_out),
    .tap_ir_out            (tap_ir_out),
    .scan_chain_select_out (scan_chain_select_out),
    .system_mode           (system_mode),
    .tdo                   (tdo),
    .tdo_oe_n              (tdo_oe_n)
  );

  assign scan_chain_internal = scan_chain_select_out <= SCAN_LAST_RSVD;
  assign scan_chain_present  = (scan_chain_select_out <= SCAN_LAST_CORE) ||
                               (EXT_BSCAN_EN && scan_chain_select_out == SCAN_BOUNDARY);

  assign drq_any  = |drq_s;
  assign bkpt_any = ex_bkpt | external_breakpoint_in;
  // Mask bits in the status register are left alone; blocking is local
  assign int_blocked = (st_ff == ST_DEBUG) || (st_ff == ST_DRQ_WAIT);
  assign int_req     = (normal_interrupt | fast_interrupt) & ~int_blocked;
  assign issue_hold  = (st_ff == ST_DRQ_WAIT) || (st_ff == ST_DEBUG);
  assign in_dbg_next = nxt_st == ST_DEBUG;
  assign wp_entry    = in_dbg_next && ((st_ff == ST_WP_ONE) || (st_ff == ST_WP_DONE));

  always_comb begin
    nxt_st      = st_ff;
    nxt_pabort  = 1'b0;
    nxt_dabort  = 1'b0;
    nxt_swi     = 1'b0;
    nxt_undef   = 1'b0;
    nxt_irq     = 1'b0;
    nxt_fiq     = 1'b0;
    nxt_discard = 1'b0;
    nxt_cancel  = 1'b0;
    case (st_ff)
      ST_RUN: begin
        if (drq_any) begin
          nxt_st = ST_DRQ_WAIT;
        end else if (watchpoint) begin
          if (data_abort || int_req) begin
            nxt_st     = ST_WP_EXC;
            nxt_dabort = data_abort;
            nxt_fiq    = !data_abort && fast_interrupt;
            nxt_irq    = !data_abort && !fast_interrupt && normal_interrupt;
          end else begin
            nxt_st = ST_WP_NEXT;
          end
        end else if (ex_valid) begin
          if (ex_prefetch_abort) begin
            nxt_pabort = 1'b1;
          end else if (int_req) begin
            nxt_fiq     = fast_interrupt;
            nxt_irq     = !fast_interrupt;
            nxt_discard = bkpt_any;
          end else if (bkpt_any) begin
            nxt_st     = ST_DEBUG;
            nxt_cancel = 1'b1;
          end else begin
            nxt_swi   = software_interrupt_instruction;
            nxt_undef = !software_interrupt_instruction && ex_undefined;
          end
        end
      end
      ST_DRQ_WAIT: begin
        if (ex_done) nxt_st = ST_DEBUG;
      end
      ST_WP_NEXT: begin
        if (ex_valid) nxt_st = ex_single_cycle ? ST_WP_ONE : ST_WP_DONE;
      end
      ST_WP_ONE: begin
        nxt_st     = ST_DEBUG;
        nxt_cancel = 1'b1;
      end
      ST_WP_DONE: begin
        if (ex_done) begin
          nxt_st     = ST_DEBUG;
          nxt_cancel = 1'b1;
        end
      end
      ST_WP_EXC: begin
        if (exc_entry_done) nxt_st = ST_DEBUG;
      end
      ST_DEBUG: begin
        if (debug_restart) nxt_st = ST_RUN;
      end
      default: nxt_st = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff             <= ST_RUN;
      debug_acknowledge <= 1'b0;
    end else begin
      st_ff             <= nxt_st;
      debug_acknowledge <= in_dbg_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      take_prefetch_abort <= 1'b0;
      take_data_abort     <= 1'b0;
      take_swi            <= 1'b0;
      take_undefined      <= 1'b0;
      take_irq            <= 1'b0;
      take_fiq            <= 1'b0;
      ex_discard          <= 1'b0;
      ex_cancel           <= 1'b0;
    end else begin
      take_prefetch_abort <= nxt_pabort;
      take_data_abort     <= nxt_dabort;
      take_swi            <= nxt_swi;
      take_undefined      <= nxt_undef;
      take_irq            <= nxt_irq;
      take_fiq            <= nxt_fiq;
      ex_discard          <= nxt_discard;
      ex_cancel           <= nxt_cancel;
    end
  end

  // Resume needs a subtract of twenty to land on the cancelled instruction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      debug_pc <= '0;
    end else if (wp_entry) begin
      debug_pc <= next_pc + WP_PC_OFFSET;
    end
  end

  // Registered so the memory system sees clean idle cycles while addresses wander
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      instr_mem_request_n <= 1'b1;
      instr_sequential    <= 1'b0;
      data_mem_request_n  <= 1'b1;
      data_sequential     <= 1'b0;
    end else if (in_dbg_next) begin
      instr_mem_request_n <= 1'b1;
      instr_sequential    <= 1'b0;
      data_mem_request_n  <= 1'b1;
      data_sequential     <= 1'b0;
    end else begin
      instr_mem_request_n <= pipe_imreq_n;
      instr_sequential    <= pipe_instr_sequential;
      data_mem_request_n  <= pipe_dmreq_n;
      data_sequential     <= pipe_data_sequential;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_run_clean;
    st_ff == ST_RUN && !drq_any && !watchpoint && ex_valid;
  endsequence

  sequence s_wp_single;
    st_ff == ST_WP_NEXT && ex_valid && ex_single_cycle;
  endsequence

  sequence s_wp_exc_start;
    st_ff == ST_RUN && !drq_any && watchpoint && data_abort;
  endsequence

  a_pabort_wins: assert property (s_run_clean and ex_prefetch_abort |=>
    take_prefetch_abort && !debug_acknowledge)
    else $error("breakpoint not dropped on prefetch abort");

  a_bkpt_swi: assert property (s_run_clean and !ex_prefetch_abort && !int_req &&
    bkpt_any && software_interrupt_instruction |=> debug_acknowledge && !take_swi)
    else $error("software interrupt beat breakpoint");

  a_int_discard: assert property (s_run_clean and !ex_prefetch_abort && int_req &&
    bkpt_any |=> (take_irq || take_fiq) && ex_discard && !debug_acknowledge)
    else $error("interrupt with breakpoint mishandled");

  a_dbg_no_int: assert property (debug_acknowledge && st_ff == ST_DEBUG &&
    !debug_restart |=> !take_irq && !take_fiq && !take_data_abort && debug_acknowledge)
    else $error("interrupt or abort acted on in debug");

  a_wp_one_cycle: assert property (s_wp_single |=> !debug_acknowledge ##1
    debug_acknowledge && ex_cancel)
    else $error("single-cycle watchpoint entry timing wrong");

  a_wp_pc: assert property (st_ff == ST_WP_ONE |=>
    debug_pc == $past(next_pc) + WP_PC_OFFSET)
    else $error("watchpoint program counter wrong");

  a_wp_exc_first: assert property (s_wp_exc_start |=> take_data_abort &&
    !debug_acknowledge && (st_ff == ST_WP_EXC))
    else $error("debug entered before exception entry");

  a_wp_exc_done: assert property (st_ff == ST_WP_EXC |=>
    debug_acknowledge == $past(exc_entry_done))
    else $error("debug entry after exception entry wrong");

  a_drq_prio: assert property (st_ff == ST_RUN && drq_any && int_req |=>
    !take_irq && !take_fiq ##1 !take_irq && !take_fiq)
    else $error("interrupt beat debug request");

  a_drq_wait: assert property (st_ff == ST_DRQ_WAIT && !ex_done |=>
    !debug_acknowledge && issue_hold)
    else $error("debug entered before execute finished");

  a_mem_idle: assert property (debug_acknowledge |-> instr_mem_request_n &&
    data_mem_request_n && !instr_sequential && !data_sequential)
    else $error("memory request shown in debug");
endmodule
`default_nettype wire

// file: rtl/dbe_pkg.sv
// Constants and types for the debug entry and test port control block
// What this block does
// - Prefetch abort on a breakpointed instruction wins; the breakpoint is dropped.
// - Breakpoint beats the software interrupt or undefined instruction exception.
// - Interrupt with breakpoint at a boundary: take interrupt, discard the instruction.
// - Debug entry blocks interrupts at once, leaving status register mask bits alone.
// - After a watchpoint, the following instruction finishes before debug entry.
// - Single-cycle instruction after a watchpoint delays debug entry exactly one cycle.
// - Instruction in execute at watchpoint entry is cancelled with no state update.
// - Watchpoint entry leaves the PC twenty bytes past the next unexecuted instruction.
// - Watchpoint with abort or pending interrupt: exception entry first, then debug.
// - Internal and external debug requests are synchronised to the core clock.
// - A synchronised debug request beats any pending interrupt.
// - Debug request stops issue; debug entry waits for the execute instruction.
// - In debug both memory interfaces show internal, non-accessing cycles.
// - In debug abort and interrupt inputs are ignored.
// - Request and sequential outputs stay synchronous to the core clock in debug.
// - Three internal scan chains 0 to 2, plus optional external chain 3.
// - Chain select addresses 32 chains, 0 to 15 internal, five-bit output.
// - The test port state number is output on four bits.
// - Test reset low resets the test port controller without any test clock.
// - Test reset selects system mode and loads the identification instruction.
// - External breakpoint input is ORed with the internal breakpoint.
// - Instruction register is four bits, no parity, captures 0001.
package dbe_pkg;
  localparam logic [31:0] WP_PC_OFFSET   = 32'h0000_0014;
  localparam int          IR_W           = 4;
  localparam int          SCAN_W         = 5;
  localparam logic [3:0]  IR_CAPTURE     = 4'h1;
  localparam logic [3:0]  IR_IDCODE      = 4'hE;
  localparam logic [3:0]  IR_SCAN_N      = 4'h2;
  localparam logic [3:0]  IR_EXTEST      = 4'h0;
  localparam logic [3:0]  IR_INTEST      = 4'hC;
  localparam logic [4:0]  SCAN_RESET_SEL = 5'h03;
  localparam logic [4:0]  SCAN_CAPTURE   = 5'h10;
  localparam logic [4:0]  SCAN_LAST_CORE = 5'h02;
  localparam logic [4:0]  SCAN_BOUNDARY  = 5'h03;
  localparam logic [4:0]  SCAN_LAST_RSVD = 5'h0F;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_DRQ_WAIT = 3'b001,
    ST_WP_NEXT  = 3'b010,
    ST_WP_ONE   = 3'b011,
    ST_WP_DONE  = 3'b100,
    ST_WP_EXC   = 3'b101,
    ST_DEBUG    = 3'b110
  } dbe_core_st_t;

  typedef enum logic [3:0] {
    TAP_EXIT2_DR  = 4'b0000,
    TAP_EXIT1_DR  = 4'b0001,
    TAP_SHIFT_DR  = 4'b0010,
    TAP_PAUSE_DR  = 4'b0011,
    TAP_SELECT_IR = 4'b0100,
    TAP_UPDATE_DR = 4'b0101,
    TAP_CAPT_DR   = 4'b0110,
    TAP_SELECT_DR = 4'b0111,
    TAP_EXIT2_IR  = 4'b1000,
    TAP_EXIT1_IR  = 4'b1001,
    TAP_SHIFT_IR  = 4'b1010,
    TAP_PAUSE_IR  = 4'b1011,
    TAP_IDLE      = 4'b1100,
    TAP_UPDATE_IR = 4'b1101,
    TAP_CAPT_IR   = 4'b1110,
    TAP_RESET     = 4'b1111
  } dbe_tap_st_t;
endpackage

// file: rtl/dbe_sync2.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/10ps
`default_nettype none
module dbe_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// file: rtl/dbe_tap_ctrl.sv
// Test port state machine, instruction and scan chain select registers
`timescale 1ns/10ps
`default_nettype none
module dbe_tap_ctrl
  import dbe_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        trst_n,
  input  wire logic        tck_s,
  input  wire logic        tms_s,
  input  wire logic        tdi_s,
  output logic [3:0]       tap_state_out,
  output logic [IR_W-1:0]  tap_ir_out,
  output logic [SCAN_W-1:0] scan_chain_select_out,
  output logic             system_mode,
  output logic             tdo,
  output logic             tdo_oe_n
);
  // Test reset acts without any clock; release is not synchronised
  logic                 tap_arst;
  logic                 tck_d_ff;
  logic                 tck_rise;
  logic                 tck_fall;
  dbe_tap_st_t          st_ff;
  dbe_tap_st_t          nxt_st;
  logic [IR_W-1:0]      ir_sh_ff;
  logic [SCAN_W-1:0]    scan_sh_ff;

  assign tap_arst = rst | ~trst_n;
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;
  assign tap_state_out = st_ff;

  always_comb begin
    case (st_ff)
      TAP_RESET:     nxt_st = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:      nxt_st = tms_s ? TAP_SELECT_DR : TAP_IDLE;
      TAP_SELECT_DR: nxt_st = tms_s ? TAP_SELECT_IR : TAP_CAPT_DR;
      TAP_CAPT_DR:   nxt_st = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:  nxt_st = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:  nxt_st = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:  nxt_st = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:  nxt_st = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: nxt_st = tms_s ? TAP_SELECT_DR : TAP_IDLE;
      TAP_SELECT_IR: nxt_st = tms_s ? TAP_RESET : TAP_CAPT_IR;
      TAP_CAPT_IR:   nxt_st = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:  nxt_st = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:  nxt_st = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:  nxt_st = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:  nxt_st = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: nxt_st = tms_s ? TAP_SELECT_DR : TAP_IDLE;
      default:       nxt_st = TAP_RESET;
    endcase
  end

  always_ff @(posedge core_clk or posedge tap_arst) begin
    if (tap_arst) begin
      tck_d_ff <= 1'b0;
      st_ff    <= TAP_RESET;
    end else begin
      tck_d_ff <= tck_s;
      if (tck_rise) st_ff <= nxt_st;
    end
  end

  always_ff @(posedge core_clk or posedge tap_arst) begin
    if (tap_arst) begin
      ir_sh_ff    <= IR_CAPTURE;
      tap_ir_out  <= IR_IDCODE;
      system_mode <= 1'b1;
    end else if (tck_rise) begin
      if (st_ff == TAP_RESET) begin
        tap_ir_out  <= IR_IDCODE;
        system_mode <= 1'b1;
      end
      if (st_ff == TAP_CAPT_IR) ir_sh_ff <= IR_CAPTURE;
      if (st_ff == TAP_SHIFT_IR) ir_sh_ff <= {tdi_s, ir_sh_ff[IR_W-1:1]};
      if (st_ff == TAP_UPDATE_IR) begin
        tap_ir_out  <= ir_sh_ff;
        system_mode <= (ir_sh_ff != IR_EXTEST) && (ir_sh_ff != IR_INTEST);
      end
    end
  end

  // Chain select survives leaving the select instruction, as intended
  always_ff @(posedge core_clk or posedge tap_arst) begin
    if (tap_arst) begin
      scan_sh_ff            <= SCAN_CAPTURE;
      scan_chain_select_out <= SCAN_RESET_SEL;
    end else if (tck_rise && tap_ir_out == IR_SCAN_N) begin
      if (st_ff == TAP_CAPT_DR) scan_sh_ff <= SCAN_CAPTURE;
      if (st_ff == TAP_SHIFT_DR) scan_sh_ff <= {tdi_s, scan_sh_ff[SCAN_W-1:1]};
      if (st_ff == TAP_UPDATE_DR) scan_chain_select_out <= scan_sh_ff;
    end
  end

  always_ff @(posedge core_clk or posedge tap_arst) begin
    if (tap_arst) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n <= !((st_ff == TAP_SHIFT_IR) || (st_ff == TAP_SHIFT_DR));
      if (st_ff == TAP_SHIFT_IR) tdo <= ir_sh_ff[0];
      else if (st_ff == TAP_SHIFT_DR && tap_ir_out == IR_SCAN_N) tdo <= scan_sh_ff[0];
      else tdo <= 1'b0;
    end
  end

  a_tap_trst: assert property (@(posedge core_clk) !trst_n |=>
    (st_ff == TAP_RESET) && (tap_ir_out == IR_IDCODE) && system_mode)
    else $error("test reset did not reset the controller");
  a_ir_capture: assert property (@(posedge core_clk) disable iff (tap_arst)
    (tck_rise && st_ff == TAP_CAPT_IR) |=> ir_sh_ff == IR_CAPTURE)
    else $error("instruction capture pattern wrong");
endmodule
`default_nettype wire

// file: sim/dbe_debug_ctrl_tb_top.sv
// Self-checking bench for debug entry and test port control
`timescale 1ns/10ps
`default_nettype none
module dbe_debug_ctrl_tb_top;
  import dbe_pkg::*;
  logic core_clk, rst, ex_valid, ex_bkpt, external_breakpoint_in, ex_prefetch_abort, software_interrupt_instruction;
  logic ex_undefined, ex_single_cycle, ex_done, normal_interrupt, fast_interrupt, watchpoint, data_abort;
  logic exc_entry_done, ice_debug_request, external_debug_request, debug_restart;
  logic pipe_imreq_n, pipe_instr_sequential, pipe_dmreq_n, pipe_data_sequential, tck, tms, tdi, trst_n;
  logic [31:0] next_pc, debug_pc;
  logic take_prefetch_abort, take_data_abort, take_swi, take_undefined, take_irq, take_fiq, ex_discard;
  logic ex_cancel, issue_hold, int_blocked, debug_acknowledge, instr_mem_request_n, instr_sequential;
  logic data_mem_request_n, data_sequential, scan_chain_internal, scan_chain_present, system_mode, tdo, tdo_oe_n;
  logic [3:0] tap_state_out;
  logic [IR_W-1:0] tap_ir_out;
  logic [SCAN_W-1:0] scan_chain_select_out;
  int error_cnt = 0;
  int n_tests = 0;

  dbe_debug_ctrl dut_u (.*);
  dbe_probe_model probe_u (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

  always #12.5 core_clk = ~core_clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic leave_dbg;
    debug_restart = 1'b1;
    cyc(1);
    debug_restart = 1'b0;
    cyc(2);
    chk("ack_exit", debug_acknowledge, 0);
    chk("imreq_run", {instr_mem_request_n, instr_sequential, data_mem_request_n, data_sequential}, 4'h5);
  endtask

  // Breakpoint entry, then system noise while halted
  task automatic bkpt_entry;
    {ex_valid, ex_bkpt} = 2'b11;
    cyc(1);
    {ex_valid, ex_bkpt} = 2'b00;
    chk("ack", debug_acknowledge, 1);
    chk("cancel", ex_cancel, 1);
    chk("mreq", {instr_mem_request_n, instr_sequential, data_mem_request_n, data_sequential}, 4'hA);
    chk("blocked", int_blocked, 1);
    {normal_interrupt, ex_valid, ex_prefetch_abort, data_abort} = 4'hF;
    cyc(2);
    chk("ignored", {take_irq, take_prefetch_abort, take_data_abort}, 0);
    chk("ack_hold", debug_acknowledge, 1);
    {normal_interrupt, ex_valid, ex_prefetch_abort, data_abort} = 4'h0;
    leave_dbg();
  endtask

  // cls: pabort, swi, undef, fiq, irq, internal bkpt, external bkpt
  task automatic prio(input logic [6:0] cls, input logic [6:0] exp);
    {ex_prefetch_abort, software_interrupt_instruction, ex_undefined, fast_interrupt,
     normal_interrupt, ex_bkpt, external_breakpoint_in} = cls;
    ex_valid = 1'b1;
    cyc(1);
    {ex_prefetch_abort, software_interrupt_instruction, ex_undefined, fast_interrupt,
     normal_interrupt, ex_bkpt, external_breakpoint_in, ex_valid} = 8'h00;
    chk("prio", {take_prefetch_abort, take_swi, take_undefined, take_fiq, take_irq, ex_discard,
                 debug_acknowledge}, exp);
    if (exp[0]) leave_dbg();
    else cyc(2);
  endtask

  // one: next instruction is single-cycle, else it ends on ex_done
  task automatic wp_entry(input logic one);
    watchpoint = 1'b1;
    cyc(1);
    {watchpoint, ex_valid, ex_single_cycle} = {2'b01, one};
    cyc(1);
    {ex_valid, ex_single_cycle} = 2'b00;
    chk("wp_early", debug_acknowledge, 0);
    chk("wp_hold", ex_cancel, 0);
    if (!one) begin
      cyc(2);
      chk("wp_done_wait", debug_acknowledge, 0);
      ex_done = 1'b1;
    end
    cyc(1);
    ex_done = 1'b0;
    chk("wp_ack", debug_acknowledge, 1);
    chk("wp_cancel", ex_cancel, 1);
    chk("wp_pc", debug_pc, next_pc + 32'h0000_0014);
    leave_dbg();
  endtask

  // irq: pending interrupt instead of a data abort
  task automatic wp_exc(input logic irq);
    {watchpoint, data_abort, normal_interrupt} = {1'b1, !irq, irq};
    cyc(1);
    {watchpoint, data_abort, normal_interrupt} = 3'b000;
    chk("wp_exc", {take_data_abort, take_irq}, {!irq, irq});
    cyc(2);
    chk("wp_wait", debug_acknowledge, 0);
    exc_entry_done = 1'b1;
    cyc(1);
    exc_entry_done = 1'b0;
    chk("wp_exc_ack", debug_acknowledge, 1);
    leave_dbg();
  endtask

  // Boundary with interrupt lands on the edge the synced request arrives
  task automatic dbg_req;
    {external_debug_request, normal_interrupt} = 2'b11;
    cyc(2);
    chk("hold_sync", issue_hold, 0);
    ex_valid = 1'b1;
    cyc(1);
    ex_valid = 1'b0;
    chk("drq_hold", issue_hold, 1);
    chk("drq_irq", take_irq, 0);
    cyc(1);
    chk("drq_ack", debug_acknowledge, 0);
    {ex_done, external_debug_request} = 2'b10;
    cyc(1);
    {ex_done, normal_interrupt} = 2'b00;
    chk("drq_ack", debug_acknowledge, 1);
    leave_dbg();
  endtask

  task automatic tap_seq;
    probe_u.tap_reset();
    chk("tap_rst", {tap_state_out, tap_ir_out, scan_chain_select_out}, {4'hF, 4'hE, 5'h03});
    chk("sys_mode", system_mode, 1);
    probe_u.frame(16'h0006, 16'h0000, 5);
    #200;
    chk("tap_sir", tap_state_out, TAP_SHIFT_IR);
    chk("tdo_cap", {tdo_oe_n, tdo}, 2'b01);
    probe_u.frame(16'h0018, 16'h0002, 6);
    #200;
    chk("tap_ir", {tap_state_out, tap_ir_out}, {TAP_IDLE, IR_SCAN_N});
    chk("tdo_idle", {tdo_oe_n, tdo}, 2'b10);
    probe_u.frame(16'h0181, 16'h0008, 10);
    #200;
    chk("scan_sel", {scan_chain_select_out, scan_chain_internal, scan_chain_present}, 7'h07);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {ex_valid, ex_bkpt, external_breakpoint_in, ex_prefetch_abort, software_interrupt_instruction, ex_undefined,
     ex_single_cycle, ex_done, normal_interrupt, fast_interrupt, watchpoint, data_abort, exc_entry_done,
     ice_debug_request, external_debug_request, debug_restart, pipe_imreq_n, pipe_instr_sequential, pipe_dmreq_n,
     pipe_data_sequential} = '0;
    {pipe_instr_sequential, pipe_data_sequential} = 2'b11;
    next_pc = 32'h0000_1000;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    cyc(1);
    bkpt_entry();
    prio(7'b1000010, 7'b1000000);
    prio(7'b0100010, 7'b0000001);
    prio(7'b0010010, 7'b0000001);
    prio(7'b0001010, 7'b0001010);
    prio(7'b0000101, 7'b0000110);
    prio(7'b0000001, 7'b0000001);
    prio(7'b0100000, 7'b0100000);
    prio(7'b0010000, 7'b0010000);
    wp_entry(1'b1);
    wp_entry(1'b0);
    wp_exc(1'b0);
    wp_exc(1'b1);
    dbg_req();
    tap_seq();
    end_sim();
  end

  initial begin
    #500000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: sim/dbe_probe_model.sv
// Debugger probe model driving the test port pins
`timescale 1ns/10ps
`default_nettype none
module dbe_probe_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
  end
  // Reset pulse with no clock at all
  task automatic tap_reset;
    trst_n = 1'b0;
    #300;
    trst_n = 1'b1;
    #300;
  endtask
  // Bits go out LSB first, one per test clock period
  task automatic frame(input logic [15:0] m, input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      tms = m[i];
      tdi = d[i];
      #100 tck = 1'b1;
      #100 tck = 1'b0;
    end
    // No pull-ups: idle pins must not look like held data
    tms = ~tms;
    tdi = ~tdi;
  endtask
endmodule
`default_nettype wire
